// file: inc/hdcfg_defines.vh
// Constants for the heater driver configuration register bank
`ifndef HDCFG_DEFINES_VH
`define HDCFG_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define HDCFG_ADDR_ID        8'h00
`define HDCFG_ADDR_CLS       8'h01
`define HDCFG_ADDR_FINE      8'h02
`define HDCFG_ADDR_GCC       8'h03
`define HDCFG_ADDR_AUX       8'h04
`define HDCFG_ADDR_SP1       8'h05
`define HDCFG_ADDR_SP2       8'h06
`define HDCFG_ADDR_ERR       8'h07
`define HDCFG_ADDR_CTRL      8'h08
`define HDCFG_NV_LAST        3'h7

// ----------------------------------------------------------------
// Reset and factory values
// ----------------------------------------------------------------
`define HDCFG_RST_CLS        8'h03
`define HDCFG_RST_FINE       8'h80
`define HDCFG_RST_GCC        8'h90
`define HDCFG_RST_AUX        8'h80
`define HDCFG_RST_SP         8'h00
`define HDCFG_RST_ZERO       8'h00

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define HDCFG_CLS_MSB        7
`define HDCFG_CLS_LSB        3
`define HDCFG_GCC_EN_BIT     7
`define HDCFG_GCC_RANGE_BIT  6
`define HDCFG_GCC_GAIN_MSB   4
`define HDCFG_GCC_MASK       8'hDF
`define HDCFG_CTRL_SEL_BIT   7
`define HDCFG_CTRL_BUSY_BIT  0
`define HDCFG_ERR_SIGN_BIT   7
`define HDCFG_ERR_MAG_MSB    6

// ----------------------------------------------------------------
// Decode arithmetic
// ----------------------------------------------------------------
`define HDCFG_THR_BASE_MV    11'h0C8
`define HDCFG_THR_STEP_MV    11'h032
`define HDCFG_GAIN_STEP_CDB  11'h023
`define HDCFG_GAIN_LOW_CDB   11'h230
`define HDCFG_ERR_STEP_OHM   12'h00F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HDCFG_NV_WRITE_MS    20
`define HDCFG_CLK_KHZ        25000

`endif

// file: rtl/hdcfg_nvmem.v
// Non-volatile copy of registers 01h to 07h with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "hdcfg_defines.vh"

module hdcfg_nvmem #(
  parameter [7:0] ERR_TRIM = 8'h00       // Factory resistor error value
) (
  input  wire       mclk,                 // Clock
  input  wire       resetn,               // Asynchronous reset, active low
  input  wire       ce,                   // Clock enable
  input  wire       wr_en,                // Write strobe
  input  wire [2:0] wr_addr,              // Write address
  input  wire [7:0] wr_data,              // Write data
  input  wire [2:0] rd_addr,              // Read address
  output reg  [7:0] rd_data               // Read data, registered
);

  reg [7:0] mem [0:7];
  integer   i;

  // Factory contents of each word
  function [7:0] nv_default;
    input [2:0] idx;
    begin
      case (idx)
        3'h1:    nv_default = `HDCFG_RST_CLS;
        3'h2:    nv_default = `HDCFG_RST_FINE;
        3'h3:    nv_default = `HDCFG_RST_GCC;
        3'h4:    nv_default = `HDCFG_RST_AUX;
        3'h5:    nv_default = `HDCFG_RST_SP;
        3'h6:    nv_default = `HDCFG_RST_SP;
        3'h7:    nv_default = ERR_TRIM;
        default: nv_default = `HDCFG_RST_ZERO;
      endcase
    end
  endfunction

  // Storage array and read register
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem[i] <= nv_default(i[2:0]);
      end
      rd_data <= `HDCFG_RST_ZERO;
    end else if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// file: rtl/hdcfg_regs.v
// Configuration and status register bank of the heater driver
`timescale 1ns/100ps
`default_nettype none
`include "hdcfg_defines.vh"

module hdcfg_regs #(
  parameter [7:0] DEVICE_ID       = 8'h5A,  // Arbitrary identity value
  parameter [7:0] ERR_TRIM        = 8'h00,  // Factory resistor error value
  parameter       NV_WRITE_CYCLES = `HDCFG_NV_WRITE_MS * `HDCFG_CLK_KHZ,
  parameter       CNT_W           = 20      // Width of the write cycle counter
) (
  input  wire              mclk,                 // Clock, 25 MHz
  input  wire              resetn,               // Asynchronous reset, active low
  input  wire              ce,                   // Clock enable, freezes state when low
  input  wire              req_valid,            // Register request strobe
  input  wire              req_write,            // 1 write, 0 read
  input  wire       [7:0]  req_addr,             // Register address
  input  wire       [7:0]  req_wdata,            // Write data
  output reg               rsp_valid,            // Answer strobe
  output reg               rsp_ack,              // 1 acknowledge, 0 not-acknowledge
  output reg        [7:0]  rsp_rdata,            // Read data
  input  wire       [10:0] sense_drop_mv,        // Sense resistor drop in mV
  output reg               heater_drive_output,  // Current limit drive
  output reg        [4:0]  current_limit_code,   // Current limit select
  output reg        [10:0] current_limit_mv,     // Selected drop threshold
  output reg        [7:0]  fine_setpoint_code,   // Fine setpoint trim
  output reg        [4:0]  loop_gain_code,       // Loop gain select
  output reg        [10:0] loop_gain_cdb,        // Gain in 0.01 dB, two's complement
  output reg               aux_converter_enable, // Converter on
  output reg               aux_converter_range,  // 0 gain one, 1 gain two
  output reg        [7:0]  aux_converter_code,   // Output code, zero when off
  output reg        [11:0] bridge_error_ohms,    // Resistor error, two's complement
  output reg               nv_busy,              // Non-volatile write or power-up load in progress
  output reg               load_done             // Power-up load finished
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [1:0] ST_LOAD = 2'b00;
  localparam [1:0] ST_CAPT = 2'b01;
  localparam [1:0] ST_IDLE = 2'b10;
  localparam [1:0] ST_NVWR = 2'b11;
  localparam integer     CNT_LAST_I = NV_WRITE_CYCLES - 1;
  localparam [CNT_W-1:0] CNT_LAST   = CNT_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  // Threshold drop in mV for a current limit code
  function [10:0] thr_mv;
    input [4:0] code;
    begin
      thr_mv = `HDCFG_THR_BASE_MV + {6'h00, code} * `HDCFG_THR_STEP_MV;
    end
  endfunction

  // Loop gain in hundredths of a dB
  function [10:0] gain_cdb;
    input [4:0] code;
    begin
      gain_cdb = {6'h00, code} * `HDCFG_GAIN_STEP_CDB - `HDCFG_GAIN_LOW_CDB;
    end
  endfunction

  // Sign and magnitude error to signed ohms
  function [11:0] err_ohms;
    input [7:0] val;
    reg   [11:0] mag;
    begin
      mag = {5'h00, val[`HDCFG_ERR_MAG_MSB:0]} * `HDCFG_ERR_STEP_OHM;
      if (val[`HDCFG_ERR_SIGN_BIT]) begin
        err_ohms = 12'h000 - mag;
      end else begin
        err_ohms = mag;
      end
    end
  endfunction

  // Address holds a register with a non-volatile copy that software writes
  function is_nv_rw;
    input [7:0] addr;
    begin
      is_nv_rw = (addr >= `HDCFG_ADDR_CLS) && (addr <= `HDCFG_ADDR_SP2);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [1:0]       state_reg;
  reg [2:0]       ld_idx_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [7:0]       cls_reg;
  reg [7:0]       gcc_reg;
  reg [7:0]       aux_reg;
  reg [7:0]       sp1_reg;
  reg [7:0]       sp2_reg;
  reg [7:0]       err_reg;
  reg             sel_reg;

  wire [7:0]      nv_rd_data;

  // Request decode
  reg             acc_wr;
  reg             acc_rd;
  reg             nack;
  reg             vol_we;
  reg  [7:0]      vol_addr;
  reg  [7:0]      vol_data;
  reg             nv_we;
  reg  [7:0]      rd_mux;

  // ----------------------------------------------------------------
  // Non-volatile copy
  // ----------------------------------------------------------------
  hdcfg_nvmem #(
    .ERR_TRIM (ERR_TRIM)
  ) u_nvmem (
    .mclk    (mclk),
    .resetn  (resetn),
    .ce      (ce),
    .wr_en   (nv_we),
    .wr_addr (req_addr[2:0]),
    .wr_data (req_wdata),
    .rd_addr (ld_idx_reg),
    .rd_data (nv_rd_data)
  );

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Reads always come from the volatile side
  always @* begin
    rd_mux = `HDCFG_RST_ZERO;
    if (req_addr == `HDCFG_ADDR_ID) begin
      rd_mux = DEVICE_ID;
    end else if (req_addr == `HDCFG_ADDR_CLS) begin
      rd_mux = cls_reg;
    end else if (req_addr == `HDCFG_ADDR_FINE) begin
      rd_mux = fine_setpoint_code;
    end else if (req_addr == `HDCFG_ADDR_GCC) begin
      rd_mux = gcc_reg & `HDCFG_GCC_MASK;
    end else if (req_addr == `HDCFG_ADDR_AUX) begin
      rd_mux = aux_reg;
    end else if (req_addr == `HDCFG_ADDR_SP1) begin
      rd_mux = sp1_reg;
    end else if (req_addr == `HDCFG_ADDR_SP2) begin
      rd_mux = sp2_reg;
    end else if (req_addr == `HDCFG_ADDR_ERR) begin
      rd_mux = err_reg;
    end else if (req_addr == `HDCFG_ADDR_CTRL) begin
      rd_mux = {sel_reg, 6'h00, nv_busy};
    end
  end

  // ----------------------------------------------------------------
  // Access decision
  // ----------------------------------------------------------------
  // Decide acknowledge and the volatile and non-volatile write strobes
  always @* begin
    acc_wr   = 1'b0;
    acc_rd   = 1'b0;
    nack     = 1'b0;
    vol_we   = 1'b0;
    vol_addr = req_addr;
    vol_data = req_wdata;
    nv_we    = 1'b0;
    if (ce && (state_reg == ST_CAPT)) begin
      vol_we   = 1'b1;
      vol_addr = {5'h00, ld_idx_reg};
      vol_data = nv_rd_data;
      nack     = req_valid; // Requests during the load are still answered
    end else if (ce && req_valid) begin
      if ((state_reg == ST_LOAD) || (state_reg == ST_CAPT)) begin
        nack = 1'b1;
      end else if (req_write) begin
        if (state_reg == ST_NVWR) begin
          nack = 1'b1;
        end else if (req_addr > `HDCFG_ADDR_CTRL) begin
          nack = 1'b1;
        end else begin
          acc_wr = 1'b1;
          vol_we = is_nv_rw(req_addr);
          nv_we  = is_nv_rw(req_addr) && !sel_reg;
        end
      end else if (req_addr > `HDCFG_ADDR_CTRL) begin
        nack = 1'b1;
      end else begin
        acc_rd = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control sequencer
  // ----------------------------------------------------------------
  // Power-up load, then idle and non-volatile write cycles
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= ST_LOAD;
      ld_idx_reg <= 3'h1;
      cnt_reg    <= {CNT_W{1'b0}};
      nv_busy    <= 1'b1;
      load_done  <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_LOAD: begin
          state_reg <= ST_CAPT;
        end
        ST_CAPT: begin
          if (ld_idx_reg == `HDCFG_NV_LAST) begin
            state_reg <= ST_IDLE;
            nv_busy   <= 1'b0;
            load_done <= 1'b1;
          end else begin
            ld_idx_reg <= ld_idx_reg + 3'h1;
            state_reg  <= ST_LOAD;
          end
        end
        ST_IDLE: begin
          if (nv_we) begin
            state_reg <= ST_NVWR;
            cnt_reg   <= {CNT_W{1'b0}};
            nv_busy   <= 1'b1;
          end
        end
        ST_NVWR: begin
          if (cnt_reg == CNT_LAST) begin
            state_reg <= ST_IDLE;
            nv_busy   <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + CNT_ONE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Volatile registers
  // ----------------------------------------------------------------
  // Volatile copies, written by power-up load or accepted writes
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cls_reg            <= `HDCFG_RST_CLS;
      fine_setpoint_code <= `HDCFG_RST_FINE;
      gcc_reg            <= `HDCFG_RST_GCC;
      aux_reg            <= `HDCFG_RST_AUX;
      sp1_reg            <= `HDCFG_RST_SP;
      sp2_reg            <= `HDCFG_RST_SP;
      err_reg            <= `HDCFG_RST_ZERO;
      sel_reg            <= 1'b0;
    end else if (ce) begin
      if (vol_we) begin
        if (vol_addr == `HDCFG_ADDR_CLS) begin
          cls_reg <= vol_data;
        end else if (vol_addr == `HDCFG_ADDR_FINE) begin
          fine_setpoint_code <= vol_data;
        end else if (vol_addr == `HDCFG_ADDR_GCC) begin
          gcc_reg <= vol_data & `HDCFG_GCC_MASK;
        end else if (vol_addr == `HDCFG_ADDR_AUX) begin
          aux_reg <= vol_data;
        end else if (vol_addr == `HDCFG_ADDR_SP1) begin
          sp1_reg <= vol_data;
        end else if (vol_addr == `HDCFG_ADDR_SP2) begin
          sp2_reg <= vol_data;
        end else if (vol_addr == `HDCFG_ADDR_ERR) begin
          err_reg <= vol_data;
        end
      end
      if (acc_wr && (req_addr == `HDCFG_ADDR_CTRL)) begin
        sel_reg <= req_wdata[`HDCFG_CTRL_SEL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Answer port
  // ----------------------------------------------------------------
  // One answer a cycle after each request taken while ce is high
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_ack   <= 1'b0;
      rsp_rdata <= `HDCFG_RST_ZERO;
    end else if (ce) begin
      rsp_valid <= acc_wr | acc_rd | nack;
      rsp_ack   <= acc_wr | acc_rd;
      if (acc_rd) begin
        rsp_rdata <= rd_mux;
      end else begin
        rsp_rdata <= `HDCFG_RST_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Hardware controls
  // ----------------------------------------------------------------
  // Decoded settings and the current limit comparator
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      heater_drive_output  <= 1'b0;
      current_limit_code   <= 5'h00;
      current_limit_mv     <= 11'h000;
      loop_gain_code       <= 5'h00;
      loop_gain_cdb        <= 11'h000;
      aux_converter_enable <= 1'b0;
      aux_converter_range  <= 1'b0;
      aux_converter_code   <= 8'h00;
      bridge_error_ohms    <= 12'h000;
    end else if (ce) begin
      current_limit_code <= cls_reg[`HDCFG_CLS_MSB:`HDCFG_CLS_LSB];
      current_limit_mv   <= thr_mv(cls_reg[`HDCFG_CLS_MSB:`HDCFG_CLS_LSB]);
      // Sense pin below threshold means the drop exceeds the selected value
      heater_drive_output <= (sense_drop_mv >
                              thr_mv(cls_reg[`HDCFG_CLS_MSB:`HDCFG_CLS_LSB]));
      loop_gain_code <= gcc_reg[`HDCFG_GCC_GAIN_MSB:0];
      loop_gain_cdb  <= gain_cdb(gcc_reg[`HDCFG_GCC_GAIN_MSB:0]);
      aux_converter_enable <= gcc_reg[`HDCFG_GCC_EN_BIT];
      // Range only matters while enabled
      aux_converter_range <= gcc_reg[`HDCFG_GCC_EN_BIT] &
                             gcc_reg[`HDCFG_GCC_RANGE_BIT];
      if (gcc_reg[`HDCFG_GCC_EN_BIT]) begin
        aux_converter_code <= aux_reg;
      end else begin
        aux_converter_code <= 8'h00;
      end
      bridge_error_ohms <= err_ohms(err_reg);
    end
  end

endmodule
`default_nettype wire

// file: tb/hdcfg_regs_assertions.sv
// Checker for the heater driver register bank ports
`timescale 1ns/100ps
`default_nettype none
module hdcfg_regs_assertions #(
  parameter int NV_WRITE_CYCLES = 500000
) (
  input wire logic        mclk,                 // Clock
  input wire logic        resetn,               // Reset, active low
  input wire logic        ce,                   // Clock enable
  input wire logic        req_valid,            // Request strobe
  input wire logic        req_write,            // Write select
  input wire logic [7:0]  req_addr,             // Address
  input wire logic        rsp_valid,            // Answer strobe
  input wire logic        rsp_ack,              // Acknowledge
  input wire logic [7:0]  rsp_rdata,            // Read data
  input wire logic [10:0] sense_drop_mv,        // Sense drop
  input wire logic        heater_drive_output,  // Drive output
  input wire logic [4:0]  current_limit_code,   // Limit code
  input wire logic [10:0] current_limit_mv,     // Limit threshold
  input wire logic [4:0]  loop_gain_code,       // Gain code
  input wire logic [10:0] loop_gain_cdb,        // Gain value
  input wire logic        aux_converter_enable, // Converter on
  input wire logic        aux_converter_range,  // Converter range
  input wire logic [7:0]  aux_converter_code,   // Converter code
  input wire logic        nv_busy,              // Write busy
  input wire logic        load_done             // Load finished
);
  logic [31:0] busy_cnt_reg;

  // Counts cycles spent busy so the write span can be measured
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_cnt_reg <= 32'h0;
    end else if (ce) begin
      busy_cnt_reg <= nv_busy ? busy_cnt_reg + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_wr_taken;
    req_valid && ce && req_write && load_done;
  endsequence
  sequence s_nack;
    rsp_valid && !rsp_ack && rsp_rdata == 8'h00;
  endsequence

  a_limit_decode: assert property (load_done && $past(load_done) |->
    current_limit_mv == 11'h0C8 + 11'h032 * {6'h00, current_limit_code})
    else $error("threshold decode wrong");
  a_heater_drive: assert property (load_done && $past(load_done, 2) && $past(ce) |->
    heater_drive_output == ($past(sense_drop_mv) > current_limit_mv))
    else $error("heater drive wrong");
  a_gain_decode: assert property (load_done && $past(load_done) |->
    loop_gain_cdb == {6'h00, loop_gain_code} * 11'h023 - 11'h230)
    else $error("gain decode wrong");
  a_aux_off: assert property (!aux_converter_enable |->
    aux_converter_code == 8'h00 && !aux_converter_range)
    else $error("converter not off");
  a_busy_nack: assert property (s_wr_taken ##0 nv_busy |=> s_nack)
    else $error("write during busy not refused");
  a_busy_span: assert property ($fell(nv_busy) && $past(load_done) |->
    busy_cnt_reg == NV_WRITE_CYCLES)
    else $error("busy span wrong");
  a_busy_cause: assert property ($rose(nv_busy) |-> $past(req_valid && req_write))
    else $error("busy without write");
  a_unused_zero: assert property (req_valid && ce && !req_write && load_done |=>
    ($past(req_addr) != 8'h03 || rsp_rdata[5] == 1'b0) &&
    ($past(req_addr) != 8'h08 || rsp_rdata[6:1] == 6'h00))
    else $error("unused bits not zero");
  a_load_nack: assert property (req_valid && ce && !load_done |=> s_nack)
    else $error("request during load accepted");
  a_bad_addr: assert property (req_valid && ce && req_addr > 8'h08 |=> s_nack)
    else $error("bad address accepted");
  a_quiet_rsp: assert property (!(req_valid && ce) |=> !rsp_valid)
    else $error("answer without request");
endmodule

bind hdcfg_regs hdcfg_regs_assertions #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .mclk, .resetn, .ce, .req_valid, .req_write, .req_addr, .rsp_valid, .rsp_ack,
  .rsp_rdata, .sense_drop_mv, .heater_drive_output, .current_limit_code,
  .current_limit_mv, .loop_gain_code, .loop_gain_cdb, .aux_converter_enable,
  .aux_converter_range, .aux_converter_code, .nv_busy, .load_done);
`default_nettype wire

// file: tb/hdcfg_host.sv
// Host model issuing register requests to the bank
`timescale 1ns/100ps
`default_nettype none
module hdcfg_host (
  input  wire logic       mclk,      // Clock
  output var  logic       req_valid, // Request strobe
  output var  logic       req_write, // Write select
  output var  logic [7:0] req_addr,  // Address
  output var  logic [7:0] req_wdata, // Write data
  input  wire logic       rsp_valid, // Answer strobe
  input  wire logic       rsp_ack,   // Acknowledge
  input  wire logic [7:0] rsp_rdata  // Read data
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 8'h00;
    req_wdata = 8'h00;
  end

  // One request held for a cycle, then the answer is awaited
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic ack, output logic [7:0] rd);
    int n;
    @(negedge mclk);
    req_valid = 1'b1;
    req_write = w;
    req_addr  = a;
    req_wdata = d;
    @(negedge mclk);
    req_valid = 1'b0;
    req_addr  = ~a;
    req_wdata = ~d;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    // A missing answer reads as unknown so no compare can pass on it
    ack = (rsp_valid === 1'b1) ? rsp_ack : 1'bx;
    rd  = rsp_rdata;
  endtask

  // Polls the busy flag before any further stored write
  task automatic wait_idle(output logic ok);
    logic       a;
    logic [7:0] r;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      xfer(1'b0, 8'h08, 8'h00, a, r);
      ok = a && r[0] === 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the heater driver register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic       ack;
    logic [7:0] rd;
  } hdcfg_row_t;

  logic        mclk, resetn, ce, req_valid, req_write, rsp_valid, rsp_ack;
  logic        heater, aux_en, aux_rng, nv_busy, load_done, ack_s, ok;
  logic [7:0]  req_addr, req_wdata, rsp_rdata, fine, aux_code, rd_s;
  logic [4:0]  cl_code, lg_code;
  logic [10:0] sense, cl_mv, lg_cdb, e;
  logic [11:0] err_ohms;
  int          fails, check_count;
  hdcfg_row_t  rows [20];

  hdcfg_regs #(.DEVICE_ID(8'hC3), .ERR_TRIM(8'h8B), .NV_WRITE_CYCLES(20)) u_dut (
    .mclk(mclk), .resetn(resetn), .ce(ce), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata),
    .sense_drop_mv(sense), .heater_drive_output(heater),
    .current_limit_code(cl_code), .current_limit_mv(cl_mv),
    .fine_setpoint_code(fine), .loop_gain_code(lg_code), .loop_gain_cdb(lg_cdb),
    .aux_converter_enable(aux_en), .aux_converter_range(aux_rng),
    .aux_converter_code(aux_code), .bridge_error_ohms(err_ohms),
    .nv_busy(nv_busy), .load_done(load_done));

  hdcfg_host u_host (
    .mclk(mclk), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_rdata(rsp_rdata));

  // Clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rq(input logic w, input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(w, a, d, ack_s, rd_s);
  endtask

  task automatic do_reset;
    int n;
    @(negedge mclk);
    resetn = 1'b0;
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    rq(1'b0, 8'h02, 8'h00);
    chk("load ack", 12'h0, {11'h0, ack_s});
    for (n = 0; n < 40 && load_done !== 1'b1; n++) @(negedge mclk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #(6000 * 40);
    fails++;
    report_and_stop;
  end

  initial begin
    resetn = 1'b0;
    ce     = 1'b1;
    sense  = 11'h000;
    rows = '{'{0, 8'h00, 8'h00, 1, 8'hC3}, '{0, 8'h01, 8'h00, 1, 8'h03},
             '{0, 8'h02, 8'h00, 1, 8'h80}, '{0, 8'h03, 8'h00, 1, 8'h90},
             '{0, 8'h04, 8'h00, 1, 8'h80}, '{0, 8'h05, 8'h00, 1, 8'h00},
             '{0, 8'h06, 8'h00, 1, 8'h00}, '{0, 8'h07, 8'h00, 1, 8'h8B},
             '{0, 8'h08, 8'h00, 1, 8'h00}, '{1, 8'h08, 8'hFF, 1, 8'h00},
             '{0, 8'h08, 8'h00, 1, 8'h80}, '{1, 8'h03, 8'hFF, 1, 8'h00},
             '{0, 8'h03, 8'h00, 1, 8'hDF}, '{1, 8'h07, 8'h11, 1, 8'h00},
             '{0, 8'h07, 8'h00, 1, 8'h8B}, '{1, 8'h05, 8'hAA, 1, 8'h00},
             '{0, 8'h05, 8'h00, 1, 8'hAA}, '{0, 8'h09, 8'h00, 0, 8'h00},
             '{1, 8'h04, 8'h3C, 1, 8'h00}, '{0, 8'h04, 8'h00, 1, 8'h3C}};
    do_reset;
    // Table of plain accesses, volatile only after the select write
    foreach (rows[i]) begin
      rq(rows[i].w, rows[i].a, rows[i].d);
      chk("ack", {11'h0, rows[i].ack}, {11'h0, ack_s});
      chk("rdata", {4'h0, rows[i].rd}, {4'h0, rd_s});
    end
    // Clock enable low freezes the bank, so the request goes unanswered
    rq(1'b1, 8'h02, 8'h44);
    chk("fine", 12'h044, {4'h0, fine});
    @(negedge mclk);
    ce = 1'b0;
    rq(1'b1, 8'h02, 8'h55);
    ce = 1'b1;
    chk("frozen", 12'h044, {4'h0, fine});
    chk("aux code", 12'h03C, {4'h0, aux_code});
    chk("aux en", 12'h001, {11'h0, aux_en});
    chk("aux range", 12'h001, {11'h0, aux_rng});
    chk("bridge", 12'hF5B, err_ohms);
    // Every limit code, threshold and drive at both sides of it
    for (int i = 0; i < 32; i++) begin
      rq(1'b1, 8'h01, {i[4:0], 3'h3});
      e = 11'(200 + 50 * i);
      sense = e;
      repeat (3) @(negedge mclk);
      chk("limit mv", {1'b0, e}, {1'b0, cl_mv});
      chk("limit code", {7'h0, i[4:0]}, {7'h0, cl_code});
      chk("drive low", 12'h0, {11'h0, heater});
      sense = e + 11'h001;
      repeat (2) @(negedge mclk);
      chk("drive high", 12'h1, {11'h0, heater});
    end
    // Every gain code
    for (int i = 0; i < 32; i++) begin
      rq(1'b1, 8'h03, {3'h6, i[4:0]});
      @(negedge mclk);
      chk("gain", {1'b0, 11'(i * 35 - 560)}, {1'b0, lg_cdb});
      chk("gain code", {7'h0, i[4:0]}, {7'h0, lg_code});
    end
    rq(1'b1, 8'h03, 8'h5F);
    @(negedge mclk);
    chk("aux off", 12'h0, {2'h0, aux_en, aux_rng, aux_code});
    // Stored write, refused write while busy, polling
    rq(1'b1, 8'h08, 8'h00);
    rq(1'b1, 8'h06, 8'h5C);
    chk("busy", 12'h1, {11'h0, nv_busy});
    rq(1'b1, 8'h05, 8'h11);
    chk("busy nack", 12'h0, {11'h0, ack_s});
    rq(1'b0, 8'h08, 8'h00);
    chk("status", 12'h001, {4'h0, rd_s});
    u_host.wait_idle(ok);
    chk("idle", 12'h1, {11'h0, ok});
    rq(1'b0, 8'h06, 8'h00);
    chk("stored", 12'h05C, {4'h0, rd_s});
    rq(1'b0, 8'h05, 8'h00);
    chk("kept", 12'h0AA, {4'h0, rd_s});
    // Volatile-only write leaves busy low
    rq(1'b1, 8'h08, 8'h80);
    rq(1'b1, 8'h06, 8'h77);
    chk("no busy", 12'h0, {11'h0, nv_busy});
    rq(1'b0, 8'h06, 8'h00);
    chk("volatile", 12'h077, {4'h0, rd_s});
    // Reset in mid-run reloads and clears the select bit
    do_reset;
    rq(1'b0, 8'h07, 8'h00);
    chk("reload", 12'h08B, {4'h0, rd_s});
    rq(1'b0, 8'h08, 8'h00);
    chk("select", 12'h000, {4'h0, rd_s});
    report_and_stop;
  end
endmodule
`default_nettype wire
